// ==== rtl/sar_adc_regs.svh ====
// Constants of the sampling converter control block: widths and timing counts.
// Assumes a 100 MHz core clock; included by the package, the comparator model and the bench.
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

`define RESULT_WIDTH   12
`define MSB_INDEX      4'h0_00B
`define SAR_CLEAR      12'h000
`define CLK_FREQ_MHZ   100
`define BIT_TIME_NS    120
`define BIT_CYCLES     ((`BIT_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define ACQ_TIME_NS    200
`define CNT_WIDTH      8

`endif

// ==== rtl/sar_adc_pkg.sv ====
// Types of the sampling converter control block.
// Assumes the constant header sits beside it on the include path.
`include "sar_adc_regs.svh"

package sar_adc_pkg;

    typedef enum logic [1:0]
    {
        ST_IDLE    = 2'b00,
        ST_CONVERT = 2'b01,
        ST_LATCH   = 2'b10,
        ST_FINISH  = 2'b11
    } conv_state_t;

    typedef struct packed
    {
        logic [`CNT_WIDTH-1:0] cnt;
        logic                  tick;
    } timer_state_t;

    typedef struct packed
    {
        logic                     cs_s1;
        logic                     cs_s2;
        logic                     rd_s1;
        logic                     rd_s2;
        logic                     cv_s1;
        logic                     cv_s2;
        logic                     cv_s3;
        logic                     bp_s1;
        logic                     bp_s2;
        logic                     cmp_s1;
        logic                     cmp_s2;
        conv_state_t              state;
        logic [3:0]               idx;
        logic [`RESULT_WIDTH-1:0] sar;
        logic [`RESULT_WIDTH-1:0] dac;
        logic [`RESULT_WIDTH-1:0] latch;
        logic [`RESULT_WIDTH-1:0] dout;
        logic                     oe_n;
        logic                     busy_n;
        logic                     restart;
    } ctrl_state_t;

endpackage

// ==== rtl/sar_bit_timer.sv ====
// Internal conversion clock: one tick every bit period, restarted on demand.
// Assumes restart is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps

module sar_bit_timer
(
    input  wire logic mclk,
    input  wire logic resetn,
    input  wire logic restart,
    output logic      tick
);

    localparam int BIT_CYC = `BIT_CYCLES;

    sar_adc_pkg::timer_state_t st_q;
    sar_adc_pkg::timer_state_t st_d;

    // ****************************************************************
    // Counter
    // ****************************************************************
    always_comb
    begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (restart)
        begin
            st_d.cnt = '0;
        end
        else if (st_q.cnt == `CNT_WIDTH'(BIT_CYC - 1))
        begin
            st_d.cnt = '0;
            st_d.tick = 1'b1;
        end
        else
        begin
            st_d.cnt = st_q.cnt + `CNT_WIDTH'(1);
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;

    // ****************************************************************
    // Checks
    // ****************************************************************
    tick_after_restart_a: assert property (@(posedge mclk) disable iff (!resetn)
        restart |=> !tick [*8] ##1 !tick [*4] ##1 tick)
        else $error("Bit tick not aligned to restart.");

endmodule // sar_bit_timer

// ==== rtl/sar_adc_ctrl.sv ====
// Control logic of a 12-bit successive-approximation converter with parallel host port.
// Assumes host strobes and the comparator arrive asynchronously; all are resynchronised.
// Notes on behaviour
// - Falling conversion start edge starts conversion.
// - Strobes ignored unless chip select low.
// - Data driven only with read and select low.
// - Busy low throughout a running conversion.
// - Result register cleared at conversion start.
// - Running conversion cannot be restarted.
// - Bits decided from MSB down to LSB.
// - Finished word loaded into output latches.
// - Twelve data lines, highest carries MSB.
// - Unipolar straight binary, bipolar two's complement.
`timescale 1ns/1ps

module sar_adc_ctrl
(
    input  wire logic                     mclk,
    input  wire logic                     resetn,
    input  wire logic                     cs_n,
    input  wire logic                     rd_n,
    input  wire logic                     conversion_start_n,
    input  wire logic                     bipolar,
    input  wire logic                     cmp_above,
    output logic                          busy_n,
    output logic [`RESULT_WIDTH-1:0]      dac_code,
    output logic [`RESULT_WIDTH-1:0]      data_out,
    output logic                          data_oe_n
);

    sar_adc_pkg::ctrl_state_t st_q;
    sar_adc_pkg::ctrl_state_t st_d;
    logic                     tick;
    logic                     start_fall;

    function automatic logic [`RESULT_WIDTH-1:0] bit_mask(input logic [3:0] i);
        bit_mask = 12'h001 << i;
    endfunction

    // ****************************************************************
    // Bit clock
    // ****************************************************************
    sar_bit_timer u_timer
    (
        .mclk    (mclk),
        .resetn  (resetn),
        .restart (st_q.restart),
        .tick    (tick)
    );

    // The rising edge is deliberately ignored, so a slow host cannot retrigger.
    assign start_fall = st_q.cv_s3 & ~st_q.cv_s2;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        st_d = st_q;
        // Two flops on every pin input; the start line takes a third for its edge.
        // The price is three cycles of latency on each strobe, which the host sees.
        st_d.cs_s1 = cs_n;
        st_d.cs_s2 = st_q.cs_s1;
        st_d.rd_s1 = rd_n;
        st_d.rd_s2 = st_q.rd_s1;
        st_d.cv_s1 = conversion_start_n;
        st_d.cv_s2 = st_q.cv_s1;
        st_d.cv_s3 = st_q.cv_s2;
        st_d.bp_s1 = bipolar;
        st_d.bp_s2 = st_q.bp_s1;
        st_d.cmp_s1 = cmp_above;
        st_d.cmp_s2 = st_q.cmp_s1;
        st_d.restart = 1'b0;
        case (st_q.state)
            sar_adc_pkg::ST_IDLE:
            begin
                if (start_fall && !st_q.cs_s2)
                begin
                    st_d.state = sar_adc_pkg::ST_CONVERT;
                    st_d.sar = `SAR_CLEAR;
                    st_d.idx = `MSB_INDEX;
                    st_d.restart = 1'b1;
                end
            end
            sar_adc_pkg::ST_CONVERT:
            begin
                // Further start edges fall through here unheard.
                if (tick)
                begin
                    if (st_q.cmp_s2)
                    begin
                        st_d.sar = st_q.sar | bit_mask(st_q.idx);
                    end
                    if (st_q.idx == 4'h0)
                    begin
                        st_d.state = sar_adc_pkg::ST_LATCH;
                    end
                    else
                    begin
                        st_d.idx = st_q.idx - 4'h1;
                    end
                end
            end
            sar_adc_pkg::ST_LATCH:
            begin
                // The array settles to offset binary; bipolar flips the sign bit.
                st_d.latch = st_q.bp_s2 ? (st_q.sar ^ bit_mask(`MSB_INDEX)) : st_q.sar;
                st_d.state = sar_adc_pkg::ST_FINISH;
            end
            sar_adc_pkg::ST_FINISH:
            begin
                st_d.state = sar_adc_pkg::ST_IDLE;
            end
            default:
            begin
                st_d.state = sar_adc_pkg::ST_IDLE;
            end
        endcase
        st_d.dac = (st_d.state == sar_adc_pkg::ST_CONVERT) ? (st_d.sar | bit_mask(st_d.idx))
                                                           : st_d.sar;
        st_d.busy_n = (st_d.state == sar_adc_pkg::ST_IDLE);
        st_d.dout = st_q.latch;
        st_d.oe_n = ~(~st_q.cs_s2 & ~st_q.rd_s2);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= '0;
            st_q.cs_s1 <= 1'b1;
            st_q.cs_s2 <= 1'b1;
            st_q.rd_s1 <= 1'b1;
            st_q.rd_s2 <= 1'b1;
            st_q.cv_s1 <= 1'b1;
            st_q.cv_s2 <= 1'b1;
            st_q.cv_s3 <= 1'b1;
            st_q.oe_n <= 1'b1;
            st_q.busy_n <= 1'b1;
            st_q.state <= sar_adc_pkg::ST_IDLE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign busy_n = st_q.busy_n;
    assign dac_code = st_q.dac;
    assign data_out = st_q.dout;
    assign data_oe_n = st_q.oe_n;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    start_accept_a: assert property (
        st_q.state == sar_adc_pkg::ST_IDLE && start_fall && !st_q.cs_s2
        |=> st_q.state == sar_adc_pkg::ST_CONVERT && st_q.sar == 12'h000 && st_q.idx == 4'hB)
        else $error("Start edge not accepted.");
    cs_gate_a: assert property (
        st_q.state == sar_adc_pkg::ST_IDLE && st_q.cs_s2 |=> st_q.state == sar_adc_pkg::ST_IDLE)
        else $error("Start accepted without chip select.");
    oe_gate_a: assert property (
        !data_oe_n |-> $past(!st_q.cs_s2 && !st_q.rd_s2))
        else $error("Data driven without read and select.");
    busy_level_a: assert property (
        busy_n == (st_q.state == sar_adc_pkg::ST_IDLE))
        else $error("Busy does not match conversion state.");
    no_restart_a: assert property (
        st_q.restart |-> $past(st_q.state) == sar_adc_pkg::ST_IDLE)
        else $error("Running conversion restarted.");
    msb_first_a: assert property (
        st_q.state == sar_adc_pkg::ST_CONVERT && tick && st_q.idx != 4'h0
        |=> st_q.idx == $past(st_q.idx) - 4'h1)
        else $error("Bit order broken.");
    latch_load_a: assert property (
        st_q.state == sar_adc_pkg::ST_LATCH
        |=> st_q.latch == ($past(st_q.bp_s2) ? {~$past(st_q.sar[11]), $past(st_q.sar[10:0])}
                                            : $past(st_q.sar)))
        else $error("Output latch not loaded with result.");
    busy_after_data_a: assert property (
        $rose(busy_n) |-> data_out == st_q.latch
                          && $past(st_q.latch) == st_q.latch)
        else $error("Busy rose before data was ready.");

    // Checks on the ends of a conversion and on the pins that the host sees.
    idle_hold_a: assert property (
        st_q.state == sar_adc_pkg::ST_IDLE && !start_fall
        |=> st_q.state == sar_adc_pkg::ST_IDLE)
        else $error("Conversion began without a start edge.");
    oe_release_a: assert property (
        st_q.cs_s2 || st_q.rd_s2 |=> data_oe_n)
        else $error("Data still driven after read or select went high.");
    busy_rise_a: assert property (
        $rose(busy_n)
        |-> $past(st_q.state) == sar_adc_pkg::ST_FINISH && $past(st_q.idx) == 4'h0)
        else $error("Busy rose before the last bit was decided.");
    restart_hold_a: assert property (
        st_q.state == sar_adc_pkg::ST_CONVERT && start_fall && !tick
        |=> st_q.state == sar_adc_pkg::ST_CONVERT && $stable(st_q.idx) && $stable(st_q.sar))
        else $error("Start edge disturbed a running conversion.");
    dout_follow_a: assert property (
        data_out == $past(st_q.latch))
        else $error("Data lines do not follow the output latch.");

    conv_done_c: cover property ($rose(busy_n));
    read_drive_c: cover property (!data_oe_n && !busy_n);
    start_ignored_c: cover property (start_fall && st_q.cs_s2);
    bipolar_c: cover property (st_q.state == sar_adc_pkg::ST_LATCH && st_q.bp_s2);
    kick_ignored_c: cover property (st_q.state == sar_adc_pkg::ST_CONVERT && start_fall);

endmodule // sar_adc_ctrl

// ==== tb/cmp_model.sv ====
// Comparator model facing the converter's trial code.
// Assumes level is the held input, read as that code plus half a step.
`timescale 1ns/1ps
`include "sar_adc_regs.svh"

module cmp_model
(
    input  wire logic                     mclk,
    input  wire logic [`RESULT_WIDTH-1:0] dac_code,
    input  wire logic [`RESULT_WIDTH-1:0] level,
    output logic                          cmp_above
);
    // ****************
    // Comparator
    // ****************
    // Registered so that the answer lags the trial, like a settling comparator.
    always_ff @(posedge mclk)
    begin
        cmp_above <= (level >= dac_code);
    end
endmodule // cmp_model

// ==== tb/tb.sv ====
// Self-checking bench for the converter control block.
// Assumes the comparator model file is compiled before it.
`timescale 1ns/1ps
`include "sar_adc_regs.svh"

module tb;
    logic        mclk;
    logic        resetn;
    logic        cs_n;
    logic        rd_n;
    logic        conv_n;
    logic        bipolar;
    logic        cmp_above;
    logic        busy_n;
    logic [11:0] level;
    logic [11:0] dac_code;
    logic [11:0] data_out;
    logic        data_oe_n;
    int          mismatches;
    int          compares;

    sar_adc_ctrl DUT (.mclk(mclk), .resetn(resetn), .cs_n(cs_n), .rd_n(rd_n),
        .conversion_start_n(conv_n), .bipolar(bipolar), .cmp_above(cmp_above),
        .busy_n(busy_n), .dac_code(dac_code), .data_out(data_out), .data_oe_n(data_oe_n));
    cmp_model cmp (.mclk(mclk), .dac_code(dac_code), .level(level), .cmp_above(cmp_above));

    // ****************
    // Helpers
    // ****************
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic read_word(output logic [11:0] w);
        int n;
        n = 0;
        @(posedge mclk);
        rd_n <= 1'b0;
        while (data_oe_n !== 1'b0 && n < 10)
        begin
            tick(1);
            n++;
        end
        check({11'h000, data_oe_n}, 12'h000, "drive on read");
        w = data_out;
        rd_n <= 1'b1;
        tick(6);
        check({11'h000, data_oe_n}, 12'h001, "release after read");
    endtask

    // ****************
    // Scenarios
    // ****************
    // A kick pulses the start line mid-run; the busy span shows whether it restarted.
    task automatic convert(input logic [11:0] target, input logic bip, input logic kick);
        int          n;
        logic [11:0] w;
        @(posedge mclk);
        level <= target;
        bipolar <= bip;
        tick(1);
        conv_n <= 1'b0;
        n = 0;
        while (busy_n !== 1'b0 && n < 10)
        begin
            tick(1);
            n++;
        end
        check({11'h000, busy_n}, 12'h000, "busy after start");
        n = 0;
        while (busy_n === 1'b0 && n < 200)
        begin
            tick(1);
            n++;
            if (kick && n == 2)
                conv_n <= 1'b1;
            if (kick && n == 71)
                conv_n <= 1'b0;
        end
        // Twelve bit periods of 12 cycles plus the latch steps.
        check({11'h000, n >= 144 && n <= 150}, 12'h001, "busy span");
        conv_n <= 1'b1;
        tick(5);
        check({11'h000, busy_n}, 12'h001, "rising start ignored");
        read_word(w);
        check(w, bip ? target ^ 12'h800 : target, "result");
        tick(25);
    endtask

    task automatic deselected;
        @(posedge mclk);
        cs_n <= 1'b1;
        tick(4);
        conv_n <= 1'b0;
        rd_n <= 1'b0;
        tick(20);
        check({11'h000, busy_n}, 12'h001, "start while deselected");
        check({11'h000, data_oe_n}, 12'h001, "read while deselected");
        conv_n <= 1'b1;
        rd_n <= 1'b1;
        tick(4);
        cs_n <= 1'b0;
        tick(4);
    endtask

    // ****************
    // Run control
    // ****************
    task automatic give_verdict;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // The whole run needs under 2000 cycles; 8000 leaves ample margin.
    initial
    begin
        tick(8000);
        mismatches++;
        give_verdict();
    end

    initial
    begin
        mismatches = 0;
        compares = 0;
        resetn = 1'b0;
        cs_n = 1'b0;
        rd_n = 1'b1;
        conv_n = 1'b1;
        bipolar = 1'b0;
        level = 12'h000;
        tick(4);
        resetn <= 1'b1;
        tick(4);
        check({busy_n, data_oe_n, 10'h000}, 12'hC00, "idle after reset");
        convert(12'hFFF, 1'b0, 1'b0);
        convert(12'h000, 1'b0, 1'b0);
        convert(12'hA5C, 1'b0, 1'b1);
        convert(12'h800, 1'b1, 1'b0);
        convert(12'h7FF, 1'b1, 1'b0);
        deselected();
        convert(12'h3A1, 1'b0, 1'b0);
        give_verdict();
    end
endmodule // tb
